// ===== core/acquire_level_trigger.sv
/*
 * measurement acquisition trigger: axi4-lite register file, trigger state,
 * two band detectors, bus trigger handling and sequence naming.
 * assumes one sample clock, samples synchronous to it, host owns settings.
 */
`timescale 1ns/100ps
module acquire_level_trigger #(
   parameter int unsigned      DATA_W    = 16,
   parameter logic [15:0]      LEVEL_MAX = 16'hffff,
   parameter logic [15:0]      HYST_MAX  = 16'hffff
) (
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [acq_trig_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                      s_axi_awprot,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   output logic [1:0]                           s_axi_bresp,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   input  wire logic [acq_trig_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                      s_axi_arprot,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   input  wire logic                            sample_valid,
   input  wire logic [DATA_W-1:0]               volt_sample,
   input  wire logic [DATA_W-1:0]               curr_sample,
   output logic                                 measure_start,
   output logic                                 waiting_for_trigger_flag
);
   import acq_trig_pkg::*;

   typedef enum logic {
      ST_IDLE    = 1'b0,
      ST_WAITING = 1'b1
   } trig_state_t;

   // byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // out-of-range settings saturate rather than wrap
   function automatic logic [DATA_W-1:0] clamp(input logic [31:0] v, input logic [15:0] max_v);
      logic [31:0] lim;
      lim = {16'h0000, max_v};
      if (v > lim) begin
         return DATA_W'(max_v);
      end
      return DATA_W'(v);
   endfunction

   logic                aw_held;
   logic [ADDR_W-1:0]   aw_addr;
   logic                w_held;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                do_write;
   logic [31:0]         wr_word;
   logic                wr_ok;
   logic                settings_write;
   logic                ctrl_write;
   logic [DATA_W-1:0]   level_curr;
   logic [DATA_W-1:0]   hyst_curr;
   logic [DATA_W-1:0]   level_volt;
   logic [DATA_W-1:0]   hyst_volt;
   slope_t              slope_curr;
   slope_t              slope_volt;
   source_t             source;
   func_t               func;
   logic [6:0]          count;
   logic [6:0]          done_count;
   logic                name_error;
   trig_state_t         state;
   logic                det_clear;
   logic                fire_curr;
   logic                fire_volt;
   logic                bus_trig;
   logic                event_hit;
   logic [31:0]         rd_word;
   logic                rd_ok;
   logic                seq_write_bad;

   // write address and data are taken independently, in either order
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_word       = w_data;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_comb begin
      case (aw_addr)
         OFF_CTRL, OFF_CONFIG, OFF_LEVEL_CURR, OFF_HYST_CURR, OFF_LEVEL_VOLT,
         OFF_HYST_VOLT, OFF_COUNT, OFF_SEQ1_NAME, OFF_ACQ_NAME, OFF_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign ctrl_write = do_write && (aw_addr == OFF_CTRL) && w_strb[0];
   assign settings_write = do_write && (aw_addr == OFF_CONFIG || aw_addr == OFF_LEVEL_CURR ||
                           aw_addr == OFF_HYST_CURR || aw_addr == OFF_LEVEL_VOLT ||
                           aw_addr == OFF_HYST_VOLT);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         level_curr <= '0;
         hyst_curr  <= '0;
         level_volt <= '0;
         hyst_volt  <= '0;
      end else if (do_write) begin
         case (aw_addr)
            OFF_LEVEL_CURR: level_curr <= clamp(merge(32'(level_curr), wr_word, w_strb),
                                                LEVEL_MAX);
            OFF_HYST_CURR: hyst_curr <= clamp(merge(32'(hyst_curr), wr_word, w_strb),
                                              HYST_MAX);
            OFF_LEVEL_VOLT: level_volt <= clamp(merge(32'(level_volt), wr_word, w_strb),
                                                LEVEL_MAX);
            OFF_HYST_VOLT: hyst_volt <= clamp(merge(32'(hyst_volt), wr_word, w_strb),
                                              HYST_MAX);
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         source     <= SRC_INTERNAL;
         func       <= FUNC_VOLT;
         slope_curr <= SLOPE_EITHER;
         slope_volt <= SLOPE_EITHER;
      end else if (do_write && aw_addr == OFF_CONFIG && w_strb[0]) begin
         source <= source_t'(wr_word[CFG_SOURCE]);
         func   <= func_t'(wr_word[CFG_FUNC]);
         // the unused code is refused and the old slope kept
         if (wr_word[CFG_SLOPE_C +: 2] != 2'b11) begin
            slope_curr <= slope_t'(wr_word[CFG_SLOPE_C +: 2]);
         end
         if (wr_word[CFG_SLOPE_V +: 2] != 2'b11) begin
            slope_volt <= slope_t'(wr_word[CFG_SLOPE_V +: 2]);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= COUNT_RST;
      end else if (do_write && aw_addr == OFF_COUNT && w_strb[0]) begin
         if (wr_word[7:0] < {1'b0, COUNT_MIN}) begin
            count <= COUNT_MIN;
         end else if (wr_word[7:0] > {1'b0, COUNT_MAX}) begin
            count <= COUNT_MAX;
         end else begin
            count <= wr_word[6:0];
         end
      end
   end

   // names are fixed; a full-word write of any other alias is rejected
   assign seq_write_bad = do_write && w_strb == 4'hf &&
                          ((aw_addr == OFF_SEQ1_NAME && wr_word != NAME_TRAN) ||
                           (aw_addr == OFF_ACQ_NAME && wr_word != NAME_ACQ));
   // a new rejection in the clearing cycle wins over the clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         name_error <= 1'b0;
      end else if (seq_write_bad) begin
         name_error <= 1'b1;
      end else if (do_write && aw_addr == OFF_STATUS && w_strb[0] && wr_word[STAT_NAMERR]) begin
         name_error <= 1'b0;
      end
   end

   // detectors rest while idle so no stale arming survives initiation
   assign det_clear = settings_write || state == ST_IDLE;

   band_detector #(.DATA_W(DATA_W)) u_curr_det (
      .core_clk     (core_clk),
      .rst          (rst),
      .clear        (det_clear),
      .sample_valid (sample_valid),
      .sample       (curr_sample),
      .level        (level_curr),
      .hyst         (hyst_curr),
      .slope        (slope_curr),
      .fire         (fire_curr)
   );

   band_detector #(.DATA_W(DATA_W)) u_volt_det (
      .core_clk     (core_clk),
      .rst          (rst),
      .clear        (det_clear),
      .sample_valid (sample_valid),
      .sample       (volt_sample),
      .level        (level_volt),
      .hyst         (hyst_volt),
      .slope        (slope_volt),
      .fire         (fire_volt)
   );
   assign bus_trig = ctrl_write && (wr_word[CTRL_TRG] || wr_word[CTRL_GET]);
   always_comb begin
      case (source)
         SRC_BUS: event_hit = bus_trig;
         SRC_INTERNAL: event_hit = (func == FUNC_CURR) ? fire_curr : fire_volt;
         default: event_hit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state      <= ST_IDLE;
         done_count <= '0;
      end else if (ctrl_write && wr_word[CTRL_ABORT]) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (ctrl_write && wr_word[CTRL_INIT]) begin
                  state      <= ST_WAITING;
                  done_count <= '0;
               end
            end
            ST_WAITING: begin
               if (event_hit) begin
                  done_count <= done_count + 7'h01;
                  if (done_count + 7'h01 >= count) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // abort in the same cycle suppresses the pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         measure_start <= 1'b0;
      end else begin
         measure_start <= state == ST_WAITING && event_hit &&
                          !(ctrl_write && wr_word[CTRL_ABORT]);
      end
   end
   assign waiting_for_trigger_flag = state == ST_WAITING;
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFF_CTRL: rd_word = '0;
         OFF_CONFIG: rd_word = 32'({slope_volt, slope_curr, func, source});
         OFF_LEVEL_CURR: rd_word = 32'(level_curr);
         OFF_HYST_CURR: rd_word = 32'(hyst_curr);
         OFF_LEVEL_VOLT: rd_word = 32'(level_volt);
         OFF_HYST_VOLT: rd_word = 32'(hyst_volt);
         OFF_COUNT: rd_word = 32'(count);
         OFF_SEQ1_NAME: rd_word = NAME_TRAN;
         OFF_ACQ_NAME: rd_word = NAME_ACQ;
         OFF_STATUS: begin
            rd_word = '0;
            rd_word[STAT_WAIT] = waiting_for_trigger_flag;
            rd_word[STAT_NAMERR] = name_error;
            rd_word[STAT_DONE +: 7] = done_count;
         end
         default: begin
            rd_word = '0;
            rd_ok   = 1'b0;
         end
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // acquire_level_trigger

// ===== inc/acq_trig_pkg.sv
/*
 * constants for the acquisition level trigger: register map, field layout,
 * reset values, slope and source codes, sequence names.
 * assumes a 32-bit axi4-lite register bus and unsigned sample words.
 */
// Summary of operation
// - band limits sit half the hysteresis above and below the trigger level
// - rising trigger needs a sample below lower limit, then one above upper
// - falling trigger needs a sample above upper limit, then one below lower
// - level and hysteresis run zero to maximum, per quantity, reset to zero
// - current level with current band drives internal current triggering
// - voltage level with voltage band drives internal voltage triggering
// - current slope selects rising, falling or either; resets to either
// - voltage slope is independent, same three choices, resets to either
// - with either slope, a qualified crossing in each direction triggers
// - trigger source is bus or internal detector; resets to internal
// - internal source triggers when the waveform crosses with chosen slope
// - bus trigger and group execute trigger act alike, only on bus source
// - sequence one accepts only transient name, sequence two only acquire
// - reading a sequence name register returns its current alias text
// - after each measurement wait again until count of 1 to 100 reached
// - while not initiated all trigger events and commands are ignored
// - each trigger starts a voltage and current measurement into buffer
// - abort cancels any trigger action and returns to idle uninitiated
package acq_trig_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_CONFIG     = 8'h04;
   localparam logic [7:0] OFF_LEVEL_CURR = 8'h08;
   localparam logic [7:0] OFF_HYST_CURR  = 8'h0c;
   localparam logic [7:0] OFF_LEVEL_VOLT = 8'h10;
   localparam logic [7:0] OFF_HYST_VOLT  = 8'h14;
   localparam logic [7:0] OFF_COUNT      = 8'h18;
   localparam logic [7:0] OFF_SEQ1_NAME  = 8'h1c;
   localparam logic [7:0] OFF_ACQ_NAME   = 8'h20;
   localparam logic [7:0] OFF_STATUS     = 8'h24;
   // ctrl bits, write-one pulses
   localparam int unsigned CTRL_INIT  = 0;
   localparam int unsigned CTRL_ABORT = 1;
   localparam int unsigned CTRL_TRG   = 2;
   localparam int unsigned CTRL_GET   = 3;
   // config fields
   localparam int unsigned CFG_SOURCE  = 0;
   localparam int unsigned CFG_FUNC    = 1;
   localparam int unsigned CFG_SLOPE_C = 2;
   localparam int unsigned CFG_SLOPE_V = 4;
   // status fields
   localparam int unsigned STAT_WAIT   = 0;
   localparam int unsigned STAT_NAMERR = 1;
   localparam int unsigned STAT_DONE   = 8;
   typedef enum logic [1:0] {
      SLOPE_EITHER = 2'b00,
      SLOPE_POS    = 2'b01,
      SLOPE_NEG    = 2'b10
   } slope_t;
   typedef enum logic {
      SRC_INTERNAL = 1'b0,
      SRC_BUS      = 1'b1
   } source_t;
   typedef enum logic {
      FUNC_VOLT = 1'b0,
      FUNC_CURR = 1'b1
   } func_t;
   localparam logic [6:0]  COUNT_MIN   = 7'h01;
   localparam logic [6:0]  COUNT_MAX   = 7'h64;
   localparam logic [6:0]  COUNT_RST   = 7'h01;
   localparam logic [31:0] NAME_TRAN   = 32'h5452414e;
   localparam logic [31:0] NAME_ACQ    = 32'h41435120;
   localparam logic [1:0]  measure_sequence_number = 2'h2;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// ===== core/band_detector.sv
/*
 * hysteresis band crossing detector for one measured quantity.
 * assumes unsigned samples, level and width in the same units.
 */
`timescale 1ns/100ps
module band_detector #(
   parameter int unsigned DATA_W = 16
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  clear,
   input  wire logic                  sample_valid,
   input  wire logic [DATA_W-1:0]     sample,
   input  wire logic [DATA_W-1:0]     level,
   input  wire logic [DATA_W-1:0]     hyst,
   input  wire acq_trig_pkg::slope_t  slope,
   output logic                       fire
);
   import acq_trig_pkg::*;
   localparam int unsigned SW = DATA_W + 2;
   logic signed [SW-1:0] upper;
   logic signed [SW-1:0] lower;
   logic signed [SW-1:0] value;
   logic                 below;
   logic                 above;
   logic                 armed_low;
   logic                 armed_high;
   logic                 rise_hit;
   logic                 fall_hit;

   // signed width keeps a negative lower limit from wrapping
   assign upper = $signed({2'b00, level}) + $signed({3'b000, hyst[DATA_W-1:1]});
   assign lower = $signed({2'b00, level}) - $signed({3'b000, hyst[DATA_W-1:1]});
   assign value = $signed({2'b00, sample});
   assign below = value < lower;
   assign above = value > upper;
   assign rise_hit = sample_valid && armed_low && above;
   assign fall_hit = sample_valid && armed_high && below;

   always_ff @(posedge core_clk) begin
      if (rst || clear) begin
         armed_low <= 1'b0;
      end else if (sample_valid) begin
         if (below) begin
            armed_low <= 1'b1;
         end else if (above) begin
            armed_low <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || clear) begin
         armed_high <= 1'b0;
      end else if (sample_valid) begin
         if (above) begin
            armed_high <= 1'b1;
         end else if (below) begin
            armed_high <= 1'b0;
         end
      end
   end

   always_comb begin
      case (slope)
         SLOPE_POS: fire = rise_hit;
         SLOPE_NEG: fire = fall_hit;
         SLOPE_EITHER: fire = rise_hit || fall_hit;
         default: fire = 1'b0;
      endcase
   end
endmodule // band_detector

// ===== sim/acquire_level_trigger_checker.sv
/* port-level assertions for acquire_level_trigger.
   assumes a bind onto the top module, one clock, synchronous reset. */
`timescale 1ns/100ps
module acquire_level_trigger_checker (
   input logic                            core_clk,
   input logic                            rst,
   input logic                            s_axi_awvalid,
   input logic                            s_axi_awready,
   input logic [acq_trig_pkg::ADDR_W-1:0] s_axi_awaddr,
   input logic                            s_axi_wvalid,
   input logic                            s_axi_wready,
   input logic [31:0]                     s_axi_wdata,
   input logic [3:0]                      s_axi_wstrb,
   input logic                            s_axi_bvalid,
   input logic                            s_axi_bready,
   input logic [1:0]                      s_axi_bresp,
   input logic                            s_axi_arvalid,
   input logic                            s_axi_arready,
   input logic                            s_axi_rvalid,
   input logic                            measure_start,
   input logic                            waiting_for_trigger_flag
);
   import acq_trig_pkg::*;
   logic wr_go;
   logic ctrl_go;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // only same-edge address and data count; split offers are left unchecked
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   assign ctrl_go = wr_go && s_axi_awaddr == OFF_CTRL && s_axi_wstrb[0];
   wr_answer_a: assert property (wr_go |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   wr_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer stuck");
   wr_busy_a: assert property (wr_go |=> !s_axi_awready && !s_axi_wready)
      else $error("write taken twice");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rst_quiet_a: assert property (disable iff (1'b0) rst |=>
      !measure_start && !waiting_for_trigger_flag) else $error("active after reset");
   abort_idle_a: assert property (ctrl_go && s_axi_wdata[CTRL_ABORT] |-> ##2
      !waiting_for_trigger_flag) else $error("abort left waiting");
   init_wait_a: assert property (ctrl_go && s_axi_wdata[CTRL_INIT] &&
      !s_axi_wdata[CTRL_ABORT] && !waiting_for_trigger_flag |-> ##2 waiting_for_trigger_flag)
      else $error("initiate ignored");
   start_armed_a: assert property (measure_start |-> $past(waiting_for_trigger_flag))
      else $error("trigger while idle");
   cover property (measure_start);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property ($rose(waiting_for_trigger_flag));
endmodule // acquire_level_trigger_checker

bind acquire_level_trigger acquire_level_trigger_checker checker_u (.core_clk, .rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .measure_start, .waiting_for_trigger_flag);

// ===== sim/sample_source.sv
/* model of the output sensing front end feeding samples.
   assumes targets are set by the bench; one sample every GAP cycles. */
`timescale 1ns/100ps
module sample_source #(
   parameter int unsigned GAP = 4
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [15:0] volt_target,
   input  wire logic [15:0] curr_target,
   output logic             sample_valid,
   output logic [15:0]      volt_sample,
   output logic [15:0]      curr_sample
);
   int unsigned tick;
   always_ff @(posedge core_clk) begin
      if (rst || tick == GAP - 1) tick <= 0;
      else tick <= tick + 1;
   end
   // one sample per period, lines junk between samples
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sample_valid <= 1'b0;
         volt_sample  <= 16'h0;
         curr_sample  <= 16'h0;
      end else begin
         sample_valid <= tick == GAP - 1;
         volt_sample  <= (tick == GAP - 1) ? volt_target : ~volt_sample;
         curr_sample  <= (tick == GAP - 1) ? curr_target : ~curr_sample;
      end
   end
endmodule // sample_source

// ===== sim/acquire_level_trigger_tb_top.sv
/* self-checking bench: register reset values, names, bus trigger, band
   detector slopes. assumes the sample_source model on the sample side. */
`timescale 1ns/100ps
module acquire_level_trigger_tb_top;
   import acq_trig_pkg::*;
   localparam int unsigned GAP = 4;
   logic        core_clk, rst, sample_valid, measure_start, waiting_for_trigger_flag;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] volt_sample, curr_sample, volt_target, curr_target, lv, hy;
   slope_t      sl;
   int          miscompares, num_checks, starts, n0, cycles;

   acquire_level_trigger dut_u (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sample_valid,
      .volt_sample, .curr_sample, .measure_start, .waiting_for_trigger_flag);
   sample_source #(.GAP(GAP)) source_u (.core_clk, .rst, .volt_target, .curr_target,
      .sample_valid, .volt_sample, .curr_sample);

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= s;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // two model periods, so a sample surely lands
   task automatic drive(input logic f, input logic [15:0] v);
      @(posedge core_clk);
      volt_target <= f ? 16'h0 : v;
      curr_target <= f ? v : 16'h0;
      repeat (2 * GAP) @(posedge core_clk);
   endtask
   function automatic logic [31:0] rst_val(input int i);
      case (i)
         6: return 32'h1;
         7: return NAME_TRAN;
         8: return NAME_ACQ;
         default: return 32'h0;
      endcase
   endfunction
   function automatic logic [15:0] limit(input logic [15:0] l, h, input logic up);
      return up ? l + h / 2 : l - h / 2;
   endfunction
   // either edge sees both crossings, one-way slopes one
   function automatic logic [31:0] exp_fires(input slope_t s);
      return (s == SLOPE_EITHER) ? 32'h2 : 32'h1;
   endfunction

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (measure_start === 1'b1) starts++;
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
         s_axi_araddr, s_axi_wdata, s_axi_wstrb, volt_target, curr_target} = '0;
      rst = 1'b1;
      void'($urandom(42639));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         axi_rd(8'(i * 4));
         check_word(d, rst_val(i));
      end
      axi_wr(8'h40, 32'h1, 4'hf);
      check_word(32'(r), 32'(RESP_SLVERR));
      axi_rd(8'h40);
      check_word(32'(r), 32'(RESP_SLVERR));
      $display("test reset and map done");
      axi_wr(OFF_SEQ1_NAME, NAME_ACQ, 4'hf);
      axi_rd(OFF_SEQ1_NAME);
      check_word(d, NAME_TRAN);
      axi_wr(OFF_ACQ_NAME, NAME_ACQ, 4'hf);
      axi_rd(OFF_STATUS);
      check_word(d, 32'h2);
      axi_wr(OFF_STATUS, 32'h2, 4'hf);
      $display("test names done");
      axi_wr(OFF_CONFIG, 32'h1, 4'h1);
      axi_wr(OFF_CTRL, 32'h4, 4'h1);
      axi_wr(OFF_COUNT, 32'h2, 4'h1);
      axi_wr(OFF_CTRL, 32'h1, 4'h1);
      axi_rd(OFF_STATUS);
      check_word(d, 32'h1);
      check_word(32'(starts), 32'h0);
      axi_wr(OFF_CTRL, 32'h4, 4'h1);
      axi_wr(OFF_CTRL, 32'h8, 4'h1);
      axi_rd(OFF_STATUS);
      check_word(d, 32'h200);
      check_word(32'(starts), 32'h2);
      $display("test bus trigger done");
      for (int f = 0; f < 2; f++) begin
         for (int s = 0; s < 3; s++) begin
            sl = slope_t'(s);
            lv = 16'd2000 + 16'($urandom % 60000);
            hy = (s == 0 && f == 0) ? 16'h0 : 16'($urandom % 2000);
            axi_wr(OFF_CONFIG, {26'h0, sl, sl, f[0], 1'b0}, 4'h1);
            axi_wr(f ? OFF_LEVEL_CURR : OFF_LEVEL_VOLT, {16'h0, lv}, 4'hf);
            axi_wr(f ? OFF_HYST_CURR : OFF_HYST_VOLT, {16'h0, hy}, 4'hf);
            axi_wr(OFF_COUNT, 32'h64, 4'h1);
            drive(f[0], lv);
            axi_wr(OFF_CTRL, 32'h1, 4'h1);
            n0 = starts;
            drive(f[0], limit(lv, hy, 1'b0) - 16'h1);
            drive(f[0], limit(lv, hy, 1'b1) + 16'h1);
            drive(f[0], limit(lv, hy, 1'b0) - 16'h1);
            check_word(32'(starts - n0), exp_fires(sl));
            axi_wr(OFF_CTRL, 32'h2, 4'h1);
            axi_rd(OFF_STATUS);
            check_word({31'h0, d[0]}, 32'h0);
         end
      end
      $display("test band detector done");
      report_and_stop();
   end
endmodule // acquire_level_trigger_tb_top
